/* tmcd_defines.svh */
// What this block does
// - second compare register, 32 bits, per pulse channel
// - second compare matters only in pulse mode
// - interval mode bit 15 gates match interrupt
// - zero-clear bit 0 clears counter after match
// - without zero-clear counter stops at match value
// - divide code bits 2:0 scale bus clock
// - code 0 gives f/2, code 7 f/256
// - pulse mode bit 15 unmasks second-match interrupt
// - pulse mode bit 14 unmasks first-match interrupt
// - pulse mode bit 0 sets initial output level
// - enables, zero-clear, level, divide reset to zero
// - mode 00 interval, 01 pulse, 11 reserved
// - source select 0 bus clock, 1 external
// - interval flag set on match, write 0 clears
`ifndef TMCD_DEFINES_SVH
`define TMCD_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define TMCD_OFS_PULSE_CH0 16'hf000
`define TMCD_OFS_PULSE_CH1 16'hf130
`define TMCD_OFS_CMPB_CH0 16'hf00c
`define TMCD_OFS_CMPB_CH1 16'hf10c
`define TMCD_OFS_CMPA_CH0 16'hf008
`define TMCD_OFS_CMPA_CH1 16'hf108
`define TMCD_OFS_CMPA_CH2 16'hf208
`define TMCD_OFS_DIV_CH0 16'hf020
`define TMCD_OFS_DIV_CH1 16'hf120
`define TMCD_OFS_DIV_CH2 16'hf220
`define TMCD_OFS_CTRL_CH0 16'hf004
`define TMCD_OFS_CTRL_CH1 16'hf104
`define TMCD_OFS_CTRL_CH2 16'hf204
`define TMCD_OFS_INTV_CH0 16'hf010
`define TMCD_OFS_INTV_CH1 16'hf110
`define TMCD_OFS_INTV_CH2 16'hf210
`define TMCD_OFS_STAT_CH0 16'hf014
`define TMCD_OFS_STAT_CH1 16'hf114
`define TMCD_OFS_STAT_CH2 16'hf214
`define TMCD_OFS_CNT_CH0 16'hf028
`define TMCD_OFS_CNT_CH1 16'hf128
`define TMCD_OFS_CNT_CH2 16'hf228

// ************************************************************
// field positions, codes and reset values
// ************************************************************
`define TMCD_BIT_INTV_IRQ 15
`define TMCD_BIT_ZERO_CLR 0
`define TMCD_BIT_PG_B_IRQ 15
`define TMCD_BIT_PG_A_IRQ 14
`define TMCD_BIT_PG_INIT 0
`define TMCD_BIT_SRC 2
`define TMCD_BIT_RUN 7
`define TMCD_BIT_ST_INTV 0
`define TMCD_BIT_ST_PG_A 1
`define TMCD_BIT_ST_PG_B 2
`define TMCD_MODE_INTERVAL 2'b00
`define TMCD_MODE_PULSE 2'b01
`define TMCD_RST_CMP 32'h0fffffff
`define TMCD_PRE_W 8

`endif

/* tmcd_pkg.sv */
package tmcd_pkg;
    `include "tmcd_defines.svh"

    // per-channel configuration handed to the counting logic
    typedef struct packed {
        logic [1:0] mode;
        logic src;
        logic run;
        logic zero_clr;
        logic init_level;
        logic [2:0] div;
        logic [31:0] cmp_a;
        logic [31:0] cmp_b;
    } tmcd_cfg_t;

    // one-cycle match events of one channel
    typedef struct packed {
        logic pg_b;
        logic pg_a;
        logic intv;
    } tmcd_evt_t;

    // low bits of the prescale counter that must all be one for a tick
    function automatic logic [7:0] tmcd_div_mask(input logic [2:0] code);
        logic [8:0] m;
        m = (9'h002 << code) - 9'h001;
        return m[7:0];
    endfunction
endpackage

/* tmcd_prescaler.sv */
`timescale 1ns/1ps
module tmcd_prescaler
    import tmcd_pkg::*;
#(
    parameter int PRE_W = `TMCD_PRE_W
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic enable_in,
    input wire logic src_in,
    input wire logic [2:0] div_in,
    input wire logic ext_in,
    output logic tick_out
);
    logic [PRE_W-1:0] pre_cnt;
    logic ext_prev;

    // free-running divider, held at zero while idle so the first period is full
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            pre_cnt <= '0;
        else if (ce_in)
            pre_cnt <= (enable_in && !src_in) ? pre_cnt + 1'b1 : '0;
    end

    // external input is synchronous, so one stage is enough for edge detection
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            ext_prev <= 1'b0;
        else if (ce_in)
            ext_prev <= ext_in;
    end

    // bus clock divided by two to the code plus one, or external rising edge
    always_comb
    begin
        if (!enable_in)
            tick_out = 1'b0;
        else if (src_in)
            tick_out = ext_in && !ext_prev;
        else
            tick_out = (pre_cnt & tmcd_div_mask(div_in)) == tmcd_div_mask(div_in);
    end
endmodule

/* tmcd_channel.sv */
`timescale 1ns/1ps
module tmcd_channel
    import tmcd_pkg::*;
#(
    parameter bit PULSE_OK = 1'b1
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input tmcd_cfg_t cfg_in,
    input wire logic tick_in,
    output logic [31:0] count_out,
    output tmcd_evt_t evt_out,
    output logic level_out
);
    logic intv_on;
    logic pulse_on;
    logic [31:0] next_count;

    assign intv_on = cfg_in.run && cfg_in.mode == `TMCD_MODE_INTERVAL;
    assign pulse_on = PULSE_OK && cfg_in.run && cfg_in.mode == `TMCD_MODE_PULSE;
    assign next_count = count_out + 32'h00000001;

    // counter: wrap or stop at the first compare, wrap at the second in pulse mode
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            count_out <= '0;
        else if (ce_in && tick_in)
        begin
            if (intv_on)
            begin
                if (count_out == cfg_in.cmp_a)
                begin
                    if (cfg_in.zero_clr)
                        count_out <= '0;
                end
                else
                    count_out <= next_count;
            end
            else if (pulse_on)
                count_out <= (count_out == cfg_in.cmp_b) ? '0 : next_count;
        end
    end

    // events fire on reaching a compare value, so a stopped counter fires once
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            evt_out <= '0;
        else if (ce_in)
        begin
            evt_out.intv <= tick_in && intv_on && count_out != cfg_in.cmp_a
                && next_count == cfg_in.cmp_a;
            evt_out.pg_a <= tick_in && pulse_on && count_out != cfg_in.cmp_b
                && next_count == cfg_in.cmp_a;
            evt_out.pg_b <= tick_in && pulse_on && count_out != cfg_in.cmp_b
                && next_count == cfg_in.cmp_b;
        end
    end

    // output flop: initial level outside pulse mode, toggled by the two matches
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            level_out <= 1'b0;
        else if (ce_in)
        begin
            if (!pulse_on)
                level_out <= cfg_in.init_level;
            else if (tick_in && count_out != cfg_in.cmp_b && next_count == cfg_in.cmp_b)
                level_out <= cfg_in.init_level;
            else if (tick_in && count_out != cfg_in.cmp_b && next_count == cfg_in.cmp_a)
                level_out <= !cfg_in.init_level;
        end
    end
endmodule

/* tmcd_timer.sv */
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module tmcd_timer
    import tmcd_pkg::*;
#(
    parameter int NCH = 3,
    parameter int NPG = 2,
    parameter int ADDR_W = 16
)
(
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic CE_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [NCH-1:0] EXT_COUNT_IN,
    output logic [31:0] RDATA_OUT,
    output logic IRQ_OUT,
    output logic [NCH-1:0] TIMER_OUT
);

    // ************************************************************
    // register state
    // ************************************************************
    logic [1:0] mode [NCH];
    logic src [NCH];
    logic run [NCH];
    logic [31:0] cmp_a [NCH];
    logic [31:0] cmp_b [NPG];
    logic intv_irq_en [NCH];
    logic zero_clr [NCH];
    logic [2:0] div [NCH];
    logic pg_b_en [NPG];
    logic pg_a_en [NPG];
    logic init_level [NPG];
    logic [2:0] status [NCH];

    // ************************************************************
    // address decode
    // ************************************************************
    logic [NCH-1:0] hit_ctrl;
    logic [NCH-1:0] hit_cmpa;
    logic [NCH-1:0] hit_intv;
    logic [NCH-1:0] hit_div;
    logic [NCH-1:0] hit_stat;
    logic [NCH-1:0] hit_cnt;
    logic [NPG-1:0] hit_cmpb;
    logic [NPG-1:0] hit_pulse;

    // one-hot strobes per register; unmapped addresses light none
    always_comb
    begin
        hit_ctrl = '0;
        hit_cmpa = '0;
        hit_intv = '0;
        hit_div = '0;
        hit_stat = '0;
        hit_cnt = '0;
        hit_cmpb = '0;
        hit_pulse = '0;
        case (ADDR_IN)
            `TMCD_OFS_CTRL_CH0: hit_ctrl[0] = 1'b1;
            `TMCD_OFS_CTRL_CH1: hit_ctrl[1] = 1'b1;
            `TMCD_OFS_CTRL_CH2: hit_ctrl[2] = 1'b1;
            `TMCD_OFS_CMPA_CH0: hit_cmpa[0] = 1'b1;
            `TMCD_OFS_CMPA_CH1: hit_cmpa[1] = 1'b1;
            `TMCD_OFS_CMPA_CH2: hit_cmpa[2] = 1'b1;
            `TMCD_OFS_INTV_CH0: hit_intv[0] = 1'b1;
            `TMCD_OFS_INTV_CH1: hit_intv[1] = 1'b1;
            `TMCD_OFS_INTV_CH2: hit_intv[2] = 1'b1;
            `TMCD_OFS_DIV_CH0: hit_div[0] = 1'b1;
            `TMCD_OFS_DIV_CH1: hit_div[1] = 1'b1;
            `TMCD_OFS_DIV_CH2: hit_div[2] = 1'b1;
            `TMCD_OFS_STAT_CH0: hit_stat[0] = 1'b1;
            `TMCD_OFS_STAT_CH1: hit_stat[1] = 1'b1;
            `TMCD_OFS_STAT_CH2: hit_stat[2] = 1'b1;
            `TMCD_OFS_CNT_CH0: hit_cnt[0] = 1'b1;
            `TMCD_OFS_CNT_CH1: hit_cnt[1] = 1'b1;
            `TMCD_OFS_CNT_CH2: hit_cnt[2] = 1'b1;
            `TMCD_OFS_CMPB_CH0: hit_cmpb[0] = 1'b1;
            `TMCD_OFS_CMPB_CH1: hit_cmpb[1] = 1'b1;
            `TMCD_OFS_PULSE_CH0: hit_pulse[0] = 1'b1;
            `TMCD_OFS_PULSE_CH1: hit_pulse[1] = 1'b1;
            default: ;
        endcase
    end

    // ************************************************************
    // control registers
    // ************************************************************

    // mode, source and run bits; mode 11 is stored but treated as idle
    always_ff @(posedge REF_CLK_IN)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (!RST_B_IN)
            begin
                mode[i] <= `TMCD_MODE_INTERVAL;
                src[i] <= 1'b0;
                run[i] <= 1'b0;
            end
            else if (CE_IN && WR_IN && hit_ctrl[i])
            begin
                mode[i] <= WDATA_IN[1:0];
                src[i] <= WDATA_IN[`TMCD_BIT_SRC];
                run[i] <= WDATA_IN[`TMCD_BIT_RUN];
            end
        end
    end

    // first compare value, used in interval and pulse mode
    always_ff @(posedge REF_CLK_IN)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (!RST_B_IN)
                cmp_a[i] <= `TMCD_RST_CMP;
            else if (CE_IN && WR_IN && hit_cmpa[i])
                cmp_a[i] <= WDATA_IN;
        end
    end

    // second compare value; ordering against the first is left to software
    always_ff @(posedge REF_CLK_IN)
    begin
        for (int i = 0; i < NPG; i++)
        begin
            if (!RST_B_IN)
                cmp_b[i] <= `TMCD_RST_CMP;
            else if (CE_IN && WR_IN && hit_cmpb[i])
                cmp_b[i] <= WDATA_IN;
        end
    end

    // interval mode: interrupt gate and zero-clear choice
    always_ff @(posedge REF_CLK_IN)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (!RST_B_IN)
            begin
                intv_irq_en[i] <= 1'b0;
                zero_clr[i] <= 1'b0;
            end
            else if (CE_IN && WR_IN && hit_intv[i])
            begin
                intv_irq_en[i] <= WDATA_IN[`TMCD_BIT_INTV_IRQ];
                zero_clr[i] <= WDATA_IN[`TMCD_BIT_ZERO_CLR];
            end
        end
    end

    // bus clock divide code
    always_ff @(posedge REF_CLK_IN)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (!RST_B_IN)
                div[i] <= 3'h0;
            else if (CE_IN && WR_IN && hit_div[i])
                div[i] <= WDATA_IN[2:0];
        end
    end

    // pulse mode: two interrupt gates and the starting output level
    always_ff @(posedge REF_CLK_IN)
    begin
        for (int i = 0; i < NPG; i++)
        begin
            if (!RST_B_IN)
            begin
                pg_b_en[i] <= 1'b0;
                pg_a_en[i] <= 1'b0;
                init_level[i] <= 1'b0;
            end
            else if (CE_IN && WR_IN && hit_pulse[i])
            begin
                pg_b_en[i] <= WDATA_IN[`TMCD_BIT_PG_B_IRQ];
                pg_a_en[i] <= WDATA_IN[`TMCD_BIT_PG_A_IRQ];
                init_level[i] <= WDATA_IN[`TMCD_BIT_PG_INIT];
            end
        end
    end

    // ************************************************************
    // channels
    // ************************************************************
    tmcd_cfg_t cfg [NCH];
    tmcd_evt_t evt [NCH];
    logic tick [NCH];
    logic [31:0] count [NCH];

    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gen_ch
            // the last channel has no second compare and no pulse mode
            always_comb
            begin
                cfg[g].mode = mode[g];
                cfg[g].src = src[g];
                cfg[g].run = run[g];
                cfg[g].zero_clr = zero_clr[g];
                cfg[g].div = div[g];
                cfg[g].cmp_a = cmp_a[g];
                cfg[g].init_level = (g < NPG) ? init_level[g < NPG ? g : 0] : 1'b0;
                cfg[g].cmp_b = (g < NPG) ? cmp_b[g < NPG ? g : 0] : `TMCD_RST_CMP;
            end

            tmcd_prescaler u_pre
            (
                .clk_in(REF_CLK_IN),
                .rst_b_in(RST_B_IN),
                .ce_in(CE_IN),
                .enable_in(run[g]),
                .src_in(src[g]),
                .div_in(div[g]),
                .ext_in(EXT_COUNT_IN[g]),
                .tick_out(tick[g])
            );

            tmcd_channel #(.PULSE_OK(g < NPG)) u_chan
            (
                .clk_in(REF_CLK_IN),
                .rst_b_in(RST_B_IN),
                .ce_in(CE_IN),
                .cfg_in(cfg[g]),
                .tick_in(tick[g]),
                .count_out(count[g]),
                .evt_out(evt[g]),
                .level_out(TIMER_OUT[g])
            );
        end
    endgenerate

    // ************************************************************
    // status flags and interrupt
    // ************************************************************

    // sticky match flags; writing 0 clears a bit, a same-cycle event wins
    always_ff @(posedge REF_CLK_IN)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (!RST_B_IN)
                status[i] <= 3'h0;
            else if (CE_IN)
            begin
                if (WR_IN && hit_stat[i])
                    status[i] <= (status[i] & WDATA_IN[2:0]) | evt[i];
                else
                    status[i] <= status[i] | evt[i];
            end
        end
    end

    logic next_irq;

    // flags gated by their enables; registered so the pin is glitch free
    always_comb
    begin
        next_irq = 1'b0;
        for (int i = 0; i < NCH; i++)
        begin
            next_irq = next_irq
                | (status[i][`TMCD_BIT_ST_INTV] & intv_irq_en[i]);
            if (i < NPG)
            begin
                next_irq = next_irq
                    | (status[i][`TMCD_BIT_ST_PG_A] & pg_a_en[i < NPG ? i : 0])
                    | (status[i][`TMCD_BIT_ST_PG_B] & pg_b_en[i < NPG ? i : 0]);
            end
        end
    end

    // one cycle behind the flag, both rising and falling
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_B_IN)
            IRQ_OUT <= 1'b0;
        else if (CE_IN)
            IRQ_OUT <= next_irq;
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [31:0] next_rdata;

    // reserved bits and unmapped addresses read as zero
    always_comb
    begin
        next_rdata = 32'h00000000;
        for (int i = 0; i < NCH; i++)
        begin
            if (hit_ctrl[i])
            begin
                next_rdata[1:0] = mode[i];
                next_rdata[`TMCD_BIT_SRC] = src[i];
                next_rdata[`TMCD_BIT_RUN] = run[i];
            end
            if (hit_cmpa[i])
                next_rdata = cmp_a[i];
            if (hit_intv[i])
            begin
                next_rdata[`TMCD_BIT_INTV_IRQ] = intv_irq_en[i];
                next_rdata[`TMCD_BIT_ZERO_CLR] = zero_clr[i];
            end
            if (hit_div[i])
                next_rdata[2:0] = div[i];
            if (hit_stat[i])
                next_rdata[2:0] = status[i];
            if (hit_cnt[i])
                next_rdata = count[i];
        end
        for (int i = 0; i < NPG; i++)
        begin
            if (hit_cmpb[i])
                next_rdata = cmp_b[i];
            if (hit_pulse[i])
            begin
                next_rdata[`TMCD_BIT_PG_B_IRQ] = pg_b_en[i];
                next_rdata[`TMCD_BIT_PG_A_IRQ] = pg_a_en[i];
                next_rdata[`TMCD_BIT_PG_INIT] = init_level[i];
            end
        end
    end

    // read data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_B_IN)
            RDATA_OUT <= 32'h00000000;
        else if (CE_IN)
            RDATA_OUT <= RD_IN ? next_rdata : 32'h00000000;
    end

endmodule

/* tmcd_checker.sv */
`timescale 1ns/1ps
module tmcd_checker
    import tmcd_pkg::*;
#(
    parameter int NCH = 3,
    parameter int NPG = 2,
    parameter int ADDR_W = 16
)
(
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic CE_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [NCH-1:0] EXT_COUNT_IN,
    input wire logic [31:0] RDATA_OUT,
    input wire logic IRQ_OUT,
    input wire logic [NCH-1:0] TIMER_OUT
);
    // ********
    // shadow of the interrupt enables
    // ********
    logic [6:0] irq_en;

    // follows enable writes as the block takes them, so masking is judged from the bus
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            irq_en <= 7'h00;
        end
        else if (WR_IN && CE_IN)
        begin
            case (ADDR_IN)
                16'hf010: irq_en[0] <= WDATA_IN[15];
                16'hf110: irq_en[1] <= WDATA_IN[15];
                16'hf210: irq_en[2] <= WDATA_IN[15];
                16'hf000: irq_en[4:3] <= WDATA_IN[15:14];
                16'hf130: irq_en[6:5] <= WDATA_IN[15:14];
                default: irq_en <= irq_en;
            endcase
        end
    end

    // ********
    // properties
    // ********
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    // a write followed at once by a read of the same place
    sequence s_wr_rd(logic [15:0] a);
        WR_IN && ADDR_IN == a ##1 RD_IN && ADDR_IN == a;
    endsequence

    a_reset_quiet: assert property ($rose(RST_B_IN) |-> !IRQ_OUT && TIMER_OUT == '0)
        else $error("outputs not idle after reset");
    a_cmpb_readback: assert property (s_wr_rd(16'hf00c) |=>
        RDATA_OUT == $past(WDATA_IN, 2)) else $error("second compare readback wrong");
    a_div_readback: assert property (s_wr_rd(16'hf020) |=>
        RDATA_OUT == ($past(WDATA_IN, 2) & 32'h7)) else $error("divide code readback wrong");
    a_intv_reserved: assert property (RD_IN && ADDR_IN inside
        {16'hf010, 16'hf110, 16'hf210} |=> (RDATA_OUT & 32'hffff7ffe) == 32'h0)
        else $error("interval reserved bits set");
    a_pulse_reserved: assert property (RD_IN && ADDR_IN inside
        {16'hf000, 16'hf130} |=> (RDATA_OUT & 32'hffff3ffe) == 32'h0)
        else $error("pulse reserved bits set");
    a_rdata_idle: assert property (!$past(RD_IN) && $past(CE_IN) |-> RDATA_OUT == 32'h0)
        else $error("read data outside answer cycle");
    a_ch2_low: assert property (TIMER_OUT[2] == 1'b0)
        else $error("channel 2 output driven");
    a_irq_masked: assert property (irq_en == 7'h0
        && $past(irq_en) == 7'h0 && $past(irq_en, 2) == 7'h0 |-> !IRQ_OUT)
        else $error("interrupt with all enables off");
    a_irq_fall: assert property ($fell(IRQ_OUT) |-> $past(WR_IN) || $past(WR_IN, 2)
        || $past(WR_IN, 3)) else $error("interrupt dropped without a write");
endmodule

bind tmcd_timer tmcd_checker #(.NCH(NCH), .NPG(NPG), .ADDR_W(ADDR_W)) i_chk (
    .REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .EXT_COUNT_IN(EXT_COUNT_IN),
    .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT), .TIMER_OUT(TIMER_OUT));

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
    import tmcd_pkg::*;
    logic clk;
    logic rst_b;
    logic ce;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [2:0] ext;
    logic [31:0] rdata;
    logic irq;
    logic [2:0] tmr;
    int num_errors;
    int n_tests;
    int cyc_cnt;
    int t1;
    int t2;
    int lows;
    int i;
    // register places, reset values and values after writing all ones (last is unmapped)
    logic [15:0] regs [11] = '{16'hf000, 16'hf130, 16'hf010, 16'hf110, 16'hf210, 16'hf020,
        16'hf120, 16'hf220, 16'hf00c, 16'hf10c, 16'hf300};
    logic [31:0] rstv [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0fffffff, 32'h0fffffff, 32'h0};
    logic [31:0] onesv [11] = '{32'hc001, 32'hc001, 32'h8001, 32'h8001, 32'h8001, 32'h7,
        32'h7, 32'h7, 32'hffffffff, 32'hffffffff, 32'h0};

    tmcd_timer i_dut (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .EXT_COUNT_IN(ext), .RDATA_OUT(rdata),
        .IRQ_OUT(irq), .TIMER_OUT(tmr));

    // ********
    // clock, timeout and report
    // ********
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // the slowest divide code alone needs some thousands of cycles
    always @(posedge clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ********
    // bus cycles
    // ********
    // each bus signal gets exactly one value per edge, so calls can follow back to back
    task automatic cyc(input logic w, input logic r, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        cyc(1'b1, 1'b0, a, d);
        cyc(1'b0, 1'b0, a, d);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        cyc(1'b0, 1'b1, a, 32'h0);
        cyc(1'b0, 1'b0, a, 32'h0);
        #1;
        check(rdata, exp);
    endtask

    task automatic wr_rd(input logic [15:0] a, input logic [31:0] d, input logic [31:0] exp);
        cyc(1'b1, 1'b0, a, d);
        rd_chk(a, exp);
    endtask

    // write zero to a status word and give the interrupt time to drop
    task automatic clr(input logic [15:0] a);
        wr_reg(a, 32'h0);
        repeat (2) @(posedge clk);
        #1;
    endtask

    // bounded wait for the interrupt; counts cycles with channel 1 output low
    task automatic wait_irq(output int t);
        int k;
        k = 0;
        #1;
        while (irq !== 1'b1 && k < 3000)
        begin
            @(posedge clk);
            #1;
            k++;
            lows += (tmr[1] === 1'b0);
        end
        // a wait that runs out is a failure of its own
        if (irq !== 1'b1)
            num_errors++;
        t = cyc_cnt;
    endtask

    task automatic ext_pulse();
        ext[2] <= 1'b1;
        repeat (5) @(posedge clk);
        ext[2] <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    // ********
    // scenarios
    // ********
    initial
    begin
        rst_b = 1'b0;
        ce = 1'b1;
        addr = 16'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        ext = 3'h0;
        num_errors = 0;
        n_tests = 0;
        cyc_cnt = 0;
        lows = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        // reset values, field widths, unmapped place
        for (i = 0; i < 11; i++) rd_chk(regs[i], rstv[i]);
        for (i = 0; i < 11; i++)
            wr_rd(regs[i], 32'hffffffff, onesv[i]);
        for (i = 0; i < 11; i++) wr_reg(regs[i], 32'h0);
        // interval with zero clear at every divide code; second compare below first is ignored
        wr_reg(16'hf00c, 32'h2);
        wr_reg(16'hf008, 32'h3);
        wr_reg(16'hf010, 32'h8001);
        wr_reg(16'hf004, 32'h80);
        for (i = 0; i < 8; i++)
        begin
            wr_reg(16'hf020, 32'(i));
            clr(16'hf014);
            wait_irq(t1);
            clr(16'hf014);
            wait_irq(t1);
            clr(16'hf014);
            wait_irq(t2);
            check(32'(t2 - t1), 32'(4 << (i + 1)));
        end
        // without zero clear the count stops at the match, flag is sticky
        wr_reg(16'hf008, 32'h5);
        wr_reg(16'hf010, 32'h8000);
        wr_reg(16'hf020, 32'h0);
        clr(16'hf014);
        wait_irq(t1);
        repeat (40) @(posedge clk);
        rd_chk(16'hf028, 32'h5);
        check(32'(irq), 32'h1);
        wr_reg(16'hf014, 32'h1);
        rd_chk(16'hf014, 32'h1);
        clr(16'hf014);
        repeat (40) @(posedge clk);
        rd_chk(16'hf014, 32'h0);
        check(32'(irq), 32'h0);
        // masked interval event sets the flag only
        wr_reg(16'hf010, 32'h1);
        repeat (40) @(posedge clk);
        rd_chk(16'hf014, 32'h1);
        check(32'(irq), 32'h0);
        wr_reg(16'hf010, 32'h8001);
        repeat (3) @(posedge clk);
        #1;
        check(32'(irq), 32'h1);
        wr_reg(16'hf004, 32'h0);
        wr_reg(16'hf010, 32'h0);
        clr(16'hf014);
        // pulse generator on channel 1, second-match interrupt only
        wr_reg(16'hf130, 32'h1);
        repeat (3) @(posedge clk);
        #1;
        check(32'(tmr), 32'h2);
        wr_reg(16'hf108, 32'h4);
        wr_reg(16'hf10c, 32'h8);
        wr_reg(16'hf130, 32'h8001);
        wr_reg(16'hf104, 32'h81);
        wait_irq(t1);
        check(32'(tmr), 32'h2);
        rd_chk(16'hf114, 32'h6);
        clr(16'hf114);
        lows = 0;
        wait_irq(t2);
        check(32'(t2 - t1), 32'd18);
        check(32'(lows), 32'd8);
        // first-match interrupt only: output is inverted when it fires
        wr_reg(16'hf130, 32'h4001);
        clr(16'hf114);
        wait_irq(t1);
        check(32'(tmr), 32'h0);
        wr_reg(16'hf104, 32'h0);
        wr_reg(16'hf130, 32'h0);
        clr(16'hf114);
        // external count source on channel 2
        wr_reg(16'hf208, 32'h4);
        wr_reg(16'hf210, 32'h8000);
        wr_reg(16'hf204, 32'h84);
        repeat (3) ext_pulse();
        #1;
        check(32'(irq), 32'h0);
        ext_pulse();
        #1;
        check(32'(irq), 32'h1);
        rd_chk(16'hf228, 32'h4);
        // second reset in mid-run, driven on the edge like every other input
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        check({28'h0, irq, tmr}, 32'h0);
        rd_chk(16'hf210, 32'h0);
        rd_chk(16'hf208, 32'h0fffffff);
        tally_and_finish();
    end
endmodule
